// file: lhb_host.sv
// Host end: drives strobe sequences for one byte write or read.
`timescale 1ns/10ps
module lhb_host (
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Bus pins
   lhb_if.host              bus_if,
   // Configuration
   input  wire logic        i_bus_style_sel,
   input  wire logic        i_init_req,
   input  wire logic        i_par_mode,
   // Request
   input  wire logic        i_req,
   input  wire logic        i_req_rd,
   input  wire logic        i_req_cmd,
   input  wire logic [7:0]  i_req_data,
   output logic             o_busy,
   output logic             o_done,
   output logic [7:0]       o_rd_data
);
   typedef struct packed {
      lhb_pkg::lhb_hstate_t state;
      logic [3:0] cnt;
      logic       rd;
      logic [7:0] d;
      logic       doe;
      logic       a0;
      logic       cs;
      logic       rd_e;
      logic       wr_rw;
      logic       init_n;
      logic       busy;
      logic       done;
      logic [7:0] rdata;
      logic [7:0] sh;
      logic [2:0] nbit;
   } lhb_host_st_t;
   lhb_host_st_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.init_n = !i_init_req; // RQ7
      st_d.cnt = (st_q.cnt == 4'h0) ? 4'h0 : st_q.cnt - 4'h1;
      unique case (st_q.state)
         lhb_pkg::LHB_IDLE: begin
            st_d.rd_e = !i_bus_style_sel;
            st_d.wr_rw = !i_bus_style_sel;
            if (i_req) begin
               st_d.rd = i_req_rd;
               st_d.d = i_req_data;
               st_d.a0 = !i_req_cmd; // RQ6
               st_d.cs = 1'b1; // RQ8
               st_d.doe = !i_req_rd;
               if (i_bus_style_sel) begin
                  st_d.wr_rw = i_req_rd; // RQ12
               end
               st_d.busy = 1'b1;
               st_d.cnt = lhb_pkg::STROBE_CYC;
               st_d.state = lhb_pkg::LHB_SETUP;
               st_d.sh = i_req_data;
               st_d.nbit = 3'h7;
               // Serial mode is write only; lines 0 to 5 are held low for the whole frame.
               if (!i_par_mode) begin
                  st_d.rd = 1'b0;
                  st_d.doe = 1'b1;
                  st_d.d = {i_req_data[7], 1'b0, 6'h00}; // RQ4 RQ14
               end
            end
         end
         lhb_pkg::LHB_SETUP: begin
            if (st_q.cnt == 4'h0) begin
               if (!i_par_mode) begin
                  st_d.d[lhb_pkg::SER_CLK_BIT] = 1'b1; // RQ3 RQ14
               end else if (i_bus_style_sel) begin
                  st_d.rd_e = 1'b1; // RQ11
               end else if (st_q.rd) begin
                  st_d.rd_e = 1'b0;
               end else begin
                  st_d.wr_rw = 1'b0;
               end
               st_d.cnt = lhb_pkg::STROBE_CYC;
               st_d.state = lhb_pkg::LHB_STROBE;
            end
         end
         lhb_pkg::LHB_STROBE: begin
            if (st_q.cnt == 4'h0) begin
               if (st_q.rd) begin
                  st_d.rdata = bus_if.bus;
               end
               st_d.rd_e = !i_bus_style_sel;
               if (!i_bus_style_sel) begin
                  st_d.wr_rw = 1'b1;
               end
               st_d.cnt = lhb_pkg::STROBE_CYC;
               st_d.state = lhb_pkg::LHB_HOLD;
               // Clock falls and the next bit goes out together, a full phase before the next rise.
               if (!i_par_mode) begin
                  st_d.d = {st_q.sh[6], 1'b0, 6'h00}; // RQ4 RQ14
                  st_d.sh = {st_q.sh[6:0], 1'b0};
                  if (st_q.nbit != 3'h0) begin
                     st_d.nbit = st_q.nbit - 3'h1;
                     st_d.state = lhb_pkg::LHB_SETUP;
                  end
               end
            end
         end
         lhb_pkg::LHB_HOLD: begin
            if (st_q.cnt == 4'h0) begin
               st_d.cs = 1'b0;
               st_d.doe = 1'b0;
               st_d.busy = 1'b0;
               st_d.done = 1'b1;
               st_d.state = lhb_pkg::LHB_IDLE;
            end
         end
         default: begin
            st_d.state = lhb_pkg::LHB_IDLE;
         end
      endcase
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= '{state: lhb_pkg::LHB_IDLE, rd_e: 1'b1, wr_rw: 1'b1, init_n: 1'b1, default: '0};
      end else begin
         st_q <= st_d;
      end
   end
   assign bus_if.host_d = st_q.d;
   assign bus_if.host_d_oe = {8{st_q.doe}};
   assign bus_if.cmd_data_sel = st_q.a0;
   assign bus_if.chip_sel_a_n = !st_q.cs;
   assign bus_if.chip_sel_b = st_q.cs;
   assign bus_if.rd_e = st_q.rd_e;
   assign bus_if.wr_rw = st_q.wr_rw;
   assign bus_if.init_n = st_q.init_n;
   assign o_busy = st_q.busy;
   assign o_done = st_q.done;
   assign o_rd_data = st_q.rdata;
endmodule

// file: lhb_pkg.sv
// Shared constants and types for the display host bus port, both ends.
// What this block does
// RQ1: Duty straps select 1/33, 1/49 or 1/65.
// RQ2: Eight-line bidirectional data bus in parallel mode.
// RQ3: Serial mode: data on line 7, clock line 6.
// RQ4: Host ties lines 0 to 5 in serial mode.
// RQ5: Deselected device never drives the data bus; the registered enable here stays on one cycle if select falls mid-read.
// RQ6: Selector high means data, low means command.
// RQ7: Init input low holds settings at reset, level-sensitive.
// RQ8: Transfers need select A low and B high.
// RQ9: Separate-strobe style: drive bus while read low.
// RQ10: Separate-strobe style: capture on write strobe rise.
// RQ11: Enable-strobe style: read pin is active-high enable.
// RQ12: Enable-strobe style: write pin high read, low write.
// RQ13: Style strap high enable-strobe, low separate strobes.
// RQ14: Serial bytes MSB first, sampled on rising clock.
package lhb_pkg;
   localparam int DATA_W = 8;
   localparam int SER_DATA_BIT = 7;
   localparam int SER_CLK_BIT = 6;
   localparam int BITCNT_W = 3;
   localparam logic [2:0] BITCNT_LAST = 3'h7;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   // Host strobe phase lengths in system clock cycles.
   localparam int STROBE_NS = 120;
   localparam int CLK_NS = 40;
   localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   typedef enum logic [1:0] {
      LHB_DUTY_33 = 2'h0,
      LHB_DUTY_49 = 2'h1,
      LHB_DUTY_65 = 2'h2
   } lhb_duty_t;
   typedef enum logic [3:0] {
      LHB_IDLE = 4'h1,
      LHB_SETUP = 4'h2,
      LHB_STROBE = 4'h4,
      LHB_HOLD = 4'h8
   } lhb_hstate_t;
endpackage

// file: lhb_if.sv
// Pin-level link between host and display port.
`timescale 1ns/10ps
interface lhb_if;
   logic [7:0] host_d;
   logic [7:0] host_d_oe;
   logic [7:0] dev_d;
   logic [7:0] dev_d_oe;
   logic       cmd_data_sel;
   logic       chip_sel_a_n;
   logic       chip_sel_b;
   logic       rd_e;
   logic       wr_rw;
   logic       init_n;
   logic [7:0] bus;
   assign bus = (host_d & host_d_oe) | (dev_d & dev_d_oe);
   modport host (output host_d, host_d_oe, cmd_data_sel, chip_sel_a_n, chip_sel_b, rd_e, wr_rw, init_n,
                 input bus);
   modport dev (output dev_d, dev_d_oe, input cmd_data_sel, chip_sel_a_n, chip_sel_b, rd_e, wr_rw, init_n,
                input bus);
endinterface

// file: lhb_device.sv
// Device end: decodes strobes and serial clock into byte transfers.
`timescale 1ns/10ps
module lhb_device (
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Bus pins
   lhb_if.dev               bus_if,
   // Straps
   input  wire logic        i_duty_sel_lo,
   input  wire logic        i_duty_sel_hi,
   input  wire logic        i_bus_style_sel,
   input  wire logic        i_par_mode,
   // Core side
   input  wire logic [7:0]  i_rd_data,
   output logic [7:0]       o_wr_data,
   output logic             o_wr_cmd,
   output logic             o_wr_valid,
   output logic             o_rd_taken,
   output logic [1:0]       o_duty,
   output logic             o_init
);
   typedef struct packed {
      logic [7:0] wdata;
      logic       wcmd;
      logic       wvalid;
      logic       rtaken;
      logic [1:0] duty;
      logic       init;
      logic [7:0] dout;
      logic       doe;
      logic       wr_prev;
      logic       en_prev;
      logic       scl_prev;
      logic [7:0] shift;
      logic [2:0] bitcnt;
   } lhb_dev_st_t;
   lhb_dev_st_t st_q, st_d;
   logic sel, rd_act, wr_end, en_fall;
   always_comb begin
      st_d = st_q;
      st_d.wvalid = 1'b0;
      st_d.rtaken = 1'b0;
      sel = !bus_if.chip_sel_a_n && bus_if.chip_sel_b; // RQ8
      // Style strap picks strobe meanings.
      if (i_bus_style_sel) begin // RQ13
         rd_act = bus_if.rd_e && bus_if.wr_rw; // RQ11 RQ12
      end else begin
         rd_act = !bus_if.rd_e; // RQ9
      end
      wr_end = 1'b0;
      en_fall = 1'b0;
      st_d.init = !bus_if.init_n; // RQ7
      // Duty straps sampled each cycle so the choice follows the pins.
      if (i_duty_sel_hi) begin // RQ1
         st_d.duty = lhb_pkg::LHB_DUTY_65;
      end else if (i_duty_sel_lo) begin
         st_d.duty = lhb_pkg::LHB_DUTY_49;
      end else begin
         st_d.duty = lhb_pkg::LHB_DUTY_33;
      end
      st_d.wr_prev = bus_if.wr_rw;
      st_d.en_prev = bus_if.rd_e;
      st_d.scl_prev = bus_if.bus[lhb_pkg::SER_CLK_BIT];
      st_d.doe = sel && i_par_mode && rd_act; // RQ5 RQ2
      st_d.dout = i_rd_data;
      if (st_q.doe && !st_d.doe) begin
         st_d.rtaken = 1'b1;
      end
      if (i_bus_style_sel) begin
         en_fall = st_q.en_prev && !bus_if.rd_e && !bus_if.wr_rw;
         wr_end = en_fall;
      end else begin
         wr_end = !st_q.wr_prev && bus_if.wr_rw; // RQ10
      end
      if (!bus_if.init_n) begin
         st_d.bitcnt = '0;
         st_d.doe = 1'b0;
      end else if (i_par_mode) begin
         if (sel && wr_end) begin
            st_d.wdata = bus_if.bus;
            st_d.wcmd = !bus_if.cmd_data_sel; // RQ6
            st_d.wvalid = 1'b1;
         end
      end else if (!sel) begin
         st_d.bitcnt = '0;
      end else if (!st_q.scl_prev && bus_if.bus[lhb_pkg::SER_CLK_BIT]) begin // RQ3 RQ14
         st_d.shift = {st_q.shift[6:0], bus_if.bus[lhb_pkg::SER_DATA_BIT]};
         st_d.bitcnt = st_q.bitcnt + 3'h1;
         if (st_q.bitcnt == lhb_pkg::BITCNT_LAST) begin
            st_d.wdata = {st_q.shift[6:0], bus_if.bus[lhb_pkg::SER_DATA_BIT]};
            st_d.wcmd = !bus_if.cmd_data_sel; // RQ6
            st_d.wvalid = 1'b1;
         end
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         // The write strobe idles high, so its last level starts high to avoid a false rising edge.
         st_q <= '{wr_prev: 1'b1, default: '0};
      end else begin
         st_q <= st_d;
      end
   end
   assign bus_if.dev_d = st_q.dout;
   assign bus_if.dev_d_oe = {8{st_q.doe}};
   assign o_wr_data = st_q.wdata;
   assign o_wr_cmd = st_q.wcmd;
   assign o_wr_valid = st_q.wvalid;
   assign o_rd_taken = st_q.rtaken;
   assign o_duty = st_q.duty;
   assign o_init = st_q.init;
endmodule

// file: lhb_port_properties.sv
// Concurrent checks on the pins between the host end and the display port end.
`timescale 1ns/10ps
module lhb_port_properties (
   // Clock, reset and style strap
   input logic       i_sys_clk,
   input logic       i_rst,
   input logic       i_bus_style_sel,
   // Link pins
   input logic [7:0] host_d_oe,
   input logic [7:0] dev_d_oe,
   input logic       cmd_data_sel,
   input logic       chip_sel_a_n,
   input logic       chip_sel_b,
   input logic       rd_e,
   input logic       wr_rw
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   wire sel = !chip_sel_a_n && chip_sel_b;
   wire st  = i_bus_style_sel;
   // Two-cycle antecedents leave room for a registered output enable.
   a_desel_bus_free: assert property ((!sel) [*2] |-> dev_d_oe == 8'h00) else $error("bus driven unselected");
   a_sep_read_drive: assert property ((!st && sel && !rd_e) [*2] |-> dev_d_oe == 8'hFF) else $error("no read drive");
   a_en_read_drive: assert property ((st && sel && rd_e && wr_rw) [*2] |-> dev_d_oe == 8'hFF)
      else $error("no enable read drive");
   a_write_no_drive: assert property ((!wr_rw && (st || rd_e)) [*2] |-> dev_d_oe == 8'h00)
      else $error("device drives in write");
   a_sep_wr_len: assert property (!st && $fell(wr_rw) |-> (!wr_rw) [*4] ##1 wr_rw) else $error("write strobe length");
   a_en_strobe_len: assert property (st && $rose(rd_e) |-> rd_e [*4] ##1 !rd_e) else $error("enable length");
   a_strobe_sel: assert property (!st && (!rd_e || !wr_rw) |-> sel) else $error("strobe without select");
   a_sel_stable: assert property (!st && !wr_rw |-> $stable(cmd_data_sel)) else $error("selector moved");
   a_no_contention: assert property ((host_d_oe & dev_d_oe) == 8'h00) else $error("both ends drive");
endmodule

// file: tb_lcd_host_bus_port.sv
// Bench joining host end and display port end and checking whole transfers.
`timescale 1ns/10ps
module tb_lcd_host_bus_port;
   typedef struct packed {logic st; logic rd; logic cmd; logic [7:0] d;} lhb_row_t;
   logic       clk = 1'b0, rst = 1'b1, st = 1'b0, dlo = 1'b0, dhi = 1'b0, par = 1'b1, initq = 1'b0;
   logic       req = 1'b0, req_rd = 1'b0, req_cmd = 1'b0, busy, done, wvld, wcmd, icmd, init, rtk;
   logic [7:0] req_d = 8'h00, rdd = 8'h00, wdat, idat, hrd;
   logic [1:0] duty;
   int         n_mismatch = 0, compares = 0, cyc = 0, nwr = 0, nrd = 0, k, i;
   lhb_row_t   rows [6] = '{'{1'b0, 1'b0, 1'b0, 8'hA5}, '{1'b0, 1'b0, 1'b1, 8'h3C}, '{1'b0, 1'b1, 1'b0, 8'hC3},
                           '{1'b1, 1'b0, 1'b1, 8'h5A}, '{1'b1, 1'b0, 1'b0, 8'hFF}, '{1'b1, 1'b1, 1'b1, 8'h81}};
   lhb_if lhb_if_inst ();
   lhb_device lhb_device_inst (.i_sys_clk(clk), .i_rst(rst), .bus_if(lhb_if_inst.dev), .i_duty_sel_lo(dlo),
      .i_duty_sel_hi(dhi), .i_bus_style_sel(st), .i_par_mode(par), .i_rd_data(rdd), .o_wr_data(idat),
      .o_wr_cmd(icmd), .o_wr_valid(wvld), .o_rd_taken(rtk), .o_duty(duty), .o_init(init));
   lhb_host lhb_host_inst (.i_sys_clk(clk), .i_rst(rst), .bus_if(lhb_if_inst.host), .i_bus_style_sel(st),
      .i_init_req(initq), .i_par_mode(par), .i_req(req), .i_req_rd(req_rd), .i_req_cmd(req_cmd), .i_req_data(req_d),
      .o_busy(busy), .o_done(done), .o_rd_data(hrd));
   lhb_port_properties lhb_port_properties_inst (.i_sys_clk(clk), .i_rst(rst), .i_bus_style_sel(st),
      .host_d_oe(lhb_if_inst.host_d_oe), .dev_d_oe(lhb_if_inst.dev_d_oe), .cmd_data_sel(lhb_if_inst.cmd_data_sel),
      .chip_sel_a_n(lhb_if_inst.chip_sel_a_n), .chip_sel_b(lhb_if_inst.chip_sel_b), .rd_e(lhb_if_inst.rd_e),
      .wr_rw(lhb_if_inst.wr_rw));
   initial begin
      forever #20 clk = ~clk;
   end
   // Latch each written byte so the check does not depend on pulse alignment.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wvld === 1'b1) begin
         wdat <= idat;
         wcmd <= icmd;
         nwr <= nwr + 1;
      end
      if (rtk === 1'b1) nrd <= nrd + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic xfer(input logic rd, input logic cmd, input logic [7:0] d);
      @(negedge clk);
      req = 1'b1;
      req_rd = rd;
      req_cmd = cmd;
      req_d = d;
      rdd = d;
      @(negedge clk);
      req = 1'b0;
      for (k = 0; k < 100 && done !== 1'b1; k++) @(negedge clk);
      chk("done", 8'h01, {7'h00, done});
      repeat (2) @(negedge clk);
   endtask
   task automatic complete_run();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("busy", 8'h00, {7'h00, busy});
      chk("dev_oe", 8'h00, lhb_if_inst.dev_d_oe);
      for (i = 0; i < 6; i++) begin
         st = rows[i].st;
         xfer(rows[i].rd, rows[i].cmd, rows[i].d);
         if (rows[i].rd) chk("rd_data", rows[i].d, hrd);
         else begin
            chk("wr_data", rows[i].d, wdat);
            chk("wr_cmd", {7'h00, rows[i].cmd}, {7'h00, wcmd});
         end
      end
      chk("writes", 8'h04, 8'(nwr));
      chk("reads", 8'h02, 8'(nrd));
      for (i = 0; i < 4; i++) begin
         {dhi, dlo} = 2'(i);
         repeat (3) @(negedge clk);
         chk("duty", i[1] ? 8'h02 : 8'(i), {6'h00, duty});
      end
      initq = 1'b1;
      repeat (4) @(negedge clk);
      chk("init", 8'h01, {7'h00, init});
      repeat (4) @(negedge clk);
      chk("init_held", 8'h01, {7'h00, init});
      initq = 1'b0;
      repeat (4) @(negedge clk);
      chk("init_off", 8'h00, {7'h00, init});
      // Serial and style straps move here under reset, as on a board, so idle strobe levels never glitch.
      rst = 1'b1;
      par = 1'b0;
      st = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("dev_oe_rst", 8'h00, lhb_if_inst.dev_d_oe);
      xfer(1'b0, 1'b1, 8'h96);
      chk("ser_data", 8'h96, wdat);
      chk("ser_cmd", 8'h01, {7'h00, wcmd});
      chk("serial_writes", 8'h05, 8'(nwr));
      complete_run();
   end
endmodule
